// ---- rtl/pcmf_pkg.sv ----
// constants for the performance channel mode filter
// Summary of operation
// [R1] eight channels, each with its own control
// [R2] control bits 31..25 read as zero
// [R3] host enable bit 24 gates host-mode counting
// [R4] guest bits 16..23 gate per partition id
// [R5] without hypervisor, mode enable bits stay zero
// [R6] count advances only on event and mode match
// [R7] select 0x10 counts executed non-speculative instructions
// [R8] guest access without permission raises privilege exception (here only while hypervisor_enable is set)
// [R9] reset clears every writable control field
package pcmf_pkg;
	localparam int          NUM_CHAN        = 8;
	localparam int          ADDR_W          = 8;
	localparam logic [7:0]  CTRL_BASE_OFS   = 8'h00;
	localparam logic [7:0]  PERM_OFS        = 8'h20;
	localparam logic [7:0]  STATUS_OFS      = 8'h24;
	localparam int          HE_BIT          = 24;
	localparam int          GE_LSB          = 16;
	localparam int          SEL_LSB         = 8;
	localparam int          SEL_W           = 8;
	localparam logic [31:0] CTRL_WMASK_HV   = 32'h01FF_FF00;
	localparam logic [31:0] CTRL_WMASK_NOHV = 32'h0000_FF00;
	localparam logic [31:0] CTRL_RESET      = 32'h0000_0000;
	localparam logic [7:0]  PERM_RESET      = 8'h00;
	localparam logic [7:0]  SEL_INSN_EXEC   = 8'h10;
endpackage

// ---- rtl/pcmf_top.sv ----
// mode filter and control registers for eight performance channels
//
// Local design decisions: register access over Avalon-MM and the register addresses.
`timescale 1ns/1ps
`default_nettype none
module pcmf_top #(
	parameter int NCH = pcmf_pkg::NUM_CHAN
) (
	input  wire logic                       sys_clk,
	input  wire logic                       rstn,
	input  wire logic [pcmf_pkg::ADDR_W-1:0] avs_address,
	input  wire logic                       avs_read,
	input  wire logic                       avs_write,
	input  wire logic [31:0]                avs_writedata,
	input  wire logic                       avs_guest_mode,
	output logic      [31:0]                avs_readdata,
	output logic                            avs_waitrequest,
	input  wire logic                       hypervisor_enable,
	input  wire logic                       core_guest_mode,
	input  wire logic [2:0]                 current_guest_partition_id,
	input  wire logic                       insn_executed,
	output logic      [NCH-1:0]             perf_channel_count_inc,
	output logic                            privilege_exception
);
	logic [31:0]    ctrl_r   [NCH];
	logic [31:0]    ctrl_nxt [NCH];
	logic [7:0]     perm_r, perm_nxt;
	logic           wait_r, wait_nxt;
	logic [31:0]    rdata_r, rdata_nxt;
	logic           pexc_r, pexc_nxt;
	logic [NCH-1:0] inc_r, inc_nxt;
	logic           req;
	logic           refused;
	logic           done;

	// decode of a channel control offset, shared by read and write paths
	function automatic logic is_ctrl(input logic [7:0] a, input int ch);
		return a == pcmf_pkg::CTRL_BASE_OFS + 8'(ch * 4);
	endfunction

	function automatic logic [2:0] chan_of(input logic [7:0] a);
		return a[4:2];
	endfunction

	// host/guest filter; without hypervisor there is no mode to filter on
	function automatic logic mode_ok(input logic [31:0] c, input logic hve,
	                                 input logic gm, input logic [2:0] gpid);
		logic [7:0] ge;
		ge = c[pcmf_pkg::GE_LSB +: 8];
		if (!hve)
			return 1'b1;
		else if (gm)
			return ge[gpid]; // see [R4]
		else
			return c[pcmf_pkg::HE_BIT]; // see [R3]
	endfunction

	assign req  = avs_read | avs_write;
	assign done = req & ~wait_r;

	// guest bus access to a channel whose permission bit is clear is refused while hypervisor_enable is set
	always_comb begin
		refused = 1'b0;
		if (avs_guest_mode && hypervisor_enable && avs_address < pcmf_pkg::PERM_OFS)
			refused = ~perm_r[chan_of(avs_address)]; // see [R8]
	end

	// bus slave: one wait cycle, then the answer stands for one cycle
	always_comb begin
		wait_nxt  = 1'b1;
		rdata_nxt = rdata_r;
		pexc_nxt  = 1'b0;
		if (req && wait_r) begin
			wait_nxt  = 1'b0;
			rdata_nxt = 32'h0000_0000;
			if (avs_read && !refused) begin
				for (int i = 0; i < NCH; i++)
					if (is_ctrl(avs_address, i))
						rdata_nxt = ctrl_r[i]; // see [R2]
				if (avs_address == pcmf_pkg::PERM_OFS)
					rdata_nxt = {24'h00_0000, perm_r};
				if (avs_address == pcmf_pkg::STATUS_OFS)
					rdata_nxt = {{(32-NCH){1'b0}}, inc_r};
			end
			pexc_nxt = refused; // see [R8]
		end
	end

	always_comb begin
		perm_nxt = perm_r;
		for (int i = 0; i < NCH; i++) begin
			ctrl_nxt[i] = ctrl_r[i];
			if (done && avs_write && !refused && is_ctrl(avs_address, i))
				// reserved bits never store; mode bits only with hypervisor
				ctrl_nxt[i] = avs_writedata & (hypervisor_enable ?
				              pcmf_pkg::CTRL_WMASK_HV : pcmf_pkg::CTRL_WMASK_NOHV); // see [R2] see [R5]
		end
		if (done && avs_write && !avs_guest_mode && avs_address == pcmf_pkg::PERM_OFS)
			perm_nxt = avs_writedata[7:0];
	end

	// one increment per channel; insn_executed is committed-only, never speculative
	generate
		for (genvar g = 0; g < NCH; g++) begin : g_chan
			always_comb begin
				inc_nxt[g] = insn_executed
				           && ctrl_r[g][pcmf_pkg::SEL_LSB +: pcmf_pkg::SEL_W]
				              == pcmf_pkg::SEL_INSN_EXEC // see [R7]
				           && mode_ok(ctrl_r[g], hypervisor_enable, core_guest_mode,
				                      current_guest_partition_id); // see [R6] see [R1]
			end
		end
	endgenerate

	always_ff @(posedge sys_clk) begin
		if (!rstn) begin
			for (int i = 0; i < NCH; i++)
				ctrl_r[i] <= pcmf_pkg::CTRL_RESET; // see [R9]
			perm_r  <= pcmf_pkg::PERM_RESET;
			wait_r  <= 1'b1;
			rdata_r <= 32'h0000_0000;
			pexc_r  <= 1'b0;
			inc_r   <= '0;
		end else begin
			for (int i = 0; i < NCH; i++)
				ctrl_r[i] <= ctrl_nxt[i];
			perm_r  <= perm_nxt;
			wait_r  <= wait_nxt;
			rdata_r <= rdata_nxt;
			pexc_r  <= pexc_nxt;
			inc_r   <= inc_nxt;
		end
	end

	assign avs_readdata           = rdata_r;
	assign avs_waitrequest        = wait_r;
	assign privilege_exception    = pexc_r;
	assign perf_channel_count_inc = inc_r;

	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (!rstn);

	sequence s_guest_denied;
		req && wait_r && refused;
	endsequence

	a_resv_bits_zero: assert property (ctrl_r[0][31:25] == 7'h00 && ctrl_r[7][31:25] == 7'h00) // see [R2]
		else $error("reserved control bits set");
	a_host_gate: assert property (insn_executed && hypervisor_enable && !core_guest_mode
		&& !ctrl_r[0][pcmf_pkg::HE_BIT] |=> !inc_r[0]) // see [R3]
		else $error("host count without host enable");
	a_guest_gate: assert property (insn_executed && hypervisor_enable && core_guest_mode
		&& ctrl_r[1][15:8] == pcmf_pkg::SEL_INSN_EXEC
		|=> inc_r[1] == $past(ctrl_r[1][pcmf_pkg::GE_LSB + current_guest_partition_id])) // see [R4]
		else $error("guest count gate wrong");
	a_nohv_masks: assert property (!hypervisor_enable && done && avs_write
		|=> ctrl_r[2][24:16] == $past(ctrl_r[2][24:16]) || ctrl_r[2][24:16] == 9'h000) // see [R5]
		else $error("mode bit stored without hypervisor");
	a_no_event_no_inc: assert property (!insn_executed |=> inc_r == '0) // see [R6]
		else $error("increment without event");
	a_sel_match: assert property (ctrl_r[3][15:8] != pcmf_pkg::SEL_INSN_EXEC |=> !inc_r[3]) // see [R7]
		else $error("increment with other select");
	a_priv_exc: assert property (s_guest_denied |=> privilege_exception && !avs_waitrequest
		##1 !privilege_exception) // see [R8]
		else $error("privilege exception timing");
	a_reset_clear: assert property (disable iff (1'b0) !rstn |=> ctrl_r[4] == 32'h0000_0000
		&& inc_r == '0) // see [R9]
		else $error("control not cleared by reset");
	a_bus_wait: assert property (req && wait_r |=> !avs_waitrequest ##1 avs_waitrequest)
		else $error("bus answer not one cycle");

	// handshake steps; the answer window is exactly one cycle wide
	sequence s_req_taken;
		req && wait_r;
	endsequence

	sequence s_answer_once;
		!avs_waitrequest ##1 avs_waitrequest;
	endsequence

	a_bus_handshake: assert property (s_req_taken |=> s_answer_once)
		else $error("handshake answer shape wrong");
	a_idle_wait_high: assert property (!req |=> avs_waitrequest)
		else $error("waitrequest low without request");

	// a refused access leaves no trace besides the exception pulse
	a_refused_rd_zero: assert property (req && wait_r && refused && avs_read
		|=> avs_readdata == 32'h0000_0000) // see [R8]
		else $error("refused read returned data");
	a_refused_wr_keep: assert property (refused && done && avs_write
		&& avs_address == pcmf_pkg::CTRL_BASE_OFS
		|=> ctrl_r[0] == $past(ctrl_r[0])) // see [R8]
		else $error("refused write changed control");
	a_guest_perm_keep: assert property (done && avs_write && avs_guest_mode
		&& avs_address == pcmf_pkg::PERM_OFS |=> perm_r == $past(perm_r)) // see [R8]
		else $error("guest changed permission");
	a_host_no_exc: assert property (!avs_guest_mode |=> !privilege_exception) // see [R8]
		else $error("exception on host access");

	// positive gating: the enables must let the event through, not only block it
	a_host_count: assert property (insn_executed && hypervisor_enable && !core_guest_mode
		&& ctrl_r[0][pcmf_pkg::HE_BIT]
		&& ctrl_r[0][15:8] == pcmf_pkg::SEL_INSN_EXEC |=> inc_r[0]) // see [R3]
		else $error("host count missed");
	a_nohv_count: assert property (!hypervisor_enable && insn_executed
		&& ctrl_r[5][15:8] == pcmf_pkg::SEL_INSN_EXEC |=> inc_r[5]) // see [R6]
		else $error("count missed without hypervisor");
	a_status_mirror: assert property (req && wait_r && avs_read && !refused
		&& avs_address == pcmf_pkg::STATUS_OFS
		|=> avs_readdata == {{(32-NCH){1'b0}}, $past(inc_r)}) // see [R6]
		else $error("status read wrong");

	// outputs must be quiet right after reset, whatever the bus does
	a_out_reset: assert property (disable iff (1'b0) !rstn |=> avs_waitrequest
		&& !privilege_exception && avs_readdata == 32'h0000_0000
		&& perm_r == pcmf_pkg::PERM_RESET) // see [R9]
		else $error("outputs not quiet after reset");

	generate
		for (genvar g = 0; g < NCH; g++) begin : g_chk
			a_chan_sel_gate: assert property (ctrl_r[g][15:8] != pcmf_pkg::SEL_INSN_EXEC
				|=> !inc_r[g]) // see [R7]
				else $error("channel counts with other select");
		end
	endgenerate
endmodule
`default_nettype wire

// ---- test/pcmf_core_model.sv ----
// core-side model: privilege state and committed-instruction pulses
`timescale 1ns/1ps
`default_nettype none
module pcmf_core_model (
	input  wire logic       sys_clk,
	input  wire logic       run,
	input  wire logic       hv_req,
	input  wire logic       gm_req,
	input  wire logic [2:0] id_req,
	output logic            hypervisor_enable,
	output logic            core_guest_mode,
	output logic [2:0]      current_guest_partition_id,
	output logic            insn_executed
);
	// speculative work never reaches the pulse, only committed instructions
	always_ff @(posedge sys_clk) begin
		insn_executed <= run;
		hypervisor_enable <= hv_req;
		core_guest_mode <= gm_req;
		current_guest_partition_id <= id_req;
	end
endmodule
`default_nettype wire

// ---- test/pcmf_top_tb_top.sv ----
// self-checking bench for the performance channel mode filter
`timescale 1ns/1ps
`default_nettype none
module pcmf_top_tb_top;
	logic        sys_clk, rstn, rd, wr, gmb, run, hv, gm, pe, wrq, pex, hve, cgm, ins;
	logic [7:0]  adr, inc;
	logic [31:0] wd, rdata, q;
	logic [2:0]  id, cid;
	logic [31:0] cfg [8];
	logic [3:0]  acc [8];
	int          err_count, n_tests, n;
	pcmf_top i_dut (.sys_clk(sys_clk), .rstn(rstn), .avs_address(adr), .avs_read(rd),
		.avs_write(wr), .avs_writedata(wd), .avs_guest_mode(gmb), .avs_readdata(rdata),
		.avs_waitrequest(wrq), .hypervisor_enable(hve), .core_guest_mode(cgm),
		.current_guest_partition_id(cid), .insn_executed(ins),
		.perf_channel_count_inc(inc), .privilege_exception(pex));
	pcmf_core_model i_core (.sys_clk(sys_clk), .run(run), .hv_req(hv), .gm_req(gm),
		.id_req(id), .hypervisor_enable(hve), .core_guest_mode(cgm),
		.current_guest_partition_id(cid), .insn_executed(ins));
	task automatic tally_and_finish;
		if (err_count == 0 && n_tests > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		n_tests++;
		if (got !== exp) begin
			err_count++;
			$display("[ERR] %0t got %h exp %h", $time, got, exp);
		end
	endtask
	// request held until the edge that samples waitrequest low
	task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
		int k;
		@(posedge sys_clk);
		adr <= a;
		wr <= w;
		rd <= !w;
		wd <= d;
		for (k = 0; k < 20 && wrq !== 1'b0; k++)
			@(posedge sys_clk);
		if (k == 20) begin
			err_count++;
			tally_and_finish;
		end
		q = rdata;
		pe = pex;
		wr <= 1'b0;
		rd <= 1'b0;
	endtask
	// five committed instructions under one mode, pulses summed per channel
	task automatic cnt(input logic h, input logic g, input logic [2:0] p);
		int c;
		@(posedge sys_clk);
		hv <= h;
		gm <= g;
		id <= p;
		@(posedge sys_clk);
		for (n = 0; n < 8; n++)
			acc[n] = 4'h0;
		for (c = 0; c < 12; c++) begin
			@(posedge sys_clk);
			run <= (c < 5);
			for (n = 0; n < 8; n++)
				acc[n] = acc[n] + inc[n];
		end
		for (n = 0; n < 8; n++)
			chk({28'h0, acc[n]}, (cfg[n][15:8] == 8'h10 && (!h || (g ? cfg[n][16 + p]
				: cfg[n][24]))) ? 32'h5 : 32'h0);
	endtask
	initial begin
		sys_clk = 1'b0;
		forever #5 sys_clk = ~sys_clk;
	end
	initial begin
		{rstn, rd, wr, gmb, run, gm, id, adr, wd} = '0;
		hv = 1'b1;
		err_count = 0;
		n_tests = 0;
		for (n = 0; n < 8; n++)
			cfg[n] = 32'h0000_1000 | (32'h1 << (16 + n));
		cfg[0][24] = 1'b1;
		cfg[7][15:8] = 8'h11;
		repeat (8) @(posedge sys_clk);
		rstn <= 1'b1;
		for (n = 0; n < 9; n++) begin
			bus(1'b0, 8'(4 * n), 32'h0);
			chk(q, 32'h0);
		end
		bus(1'b1, 8'h00, 32'hFFFF_FFFF);
		bus(1'b0, 8'h00, 32'h0);
		chk(q, 32'h01FF_FF00);
		hv <= 1'b0;
		repeat (2) @(posedge sys_clk);
		bus(1'b1, 8'h04, 32'hFFFF_FFFF);
		bus(1'b0, 8'h04, 32'h0);
		chk(q, 32'h0000_FF00);
		hv <= 1'b1;
		repeat (2) @(posedge sys_clk);
		for (n = 0; n < 8; n++) begin
			bus(1'b1, 8'(4 * n), cfg[n]);
			bus(1'b0, 8'(4 * n), 32'h0);
			chk(q, cfg[n]);
		end
		cnt(1'b1, 1'b0, 3'h0);
		cnt(1'b1, 1'b1, 3'h3);
		cnt(1'b1, 1'b1, 3'h7);
		cnt(1'b0, 1'b1, 3'h5);
		cnt(1'b1, 1'b0, 3'h0);
		bus(1'b0, 8'h24, 32'h0);
		chk(q, 32'h0);
		gmb <= 1'b1;
		bus(1'b0, 8'h08, 32'h0);
		chk(q, 32'h0);
		chk({31'h0, pe}, 32'h1);
		gmb <= 1'b0;
		bus(1'b1, 8'h20, 32'h0000_0004);
		gmb <= 1'b1;
		bus(1'b0, 8'h08, 32'h0);
		chk(q, cfg[2]);
		chk({31'h0, pe}, 32'h0);
		bus(1'b0, 8'h40, 32'h0);
		chk(q, 32'h0);
		tally_and_finish;
	end
endmodule
`default_nettype wire
